// ==== verilog/dcmcb_bank.sv ====
// Data cache machine check bank: control, mask, status and address logs
//
// Overview of operation
// - Exception needs global and local enable
// - Locally disabled errors still logged, not raised
// - Global enable clear: no log, no report
// - Bits 0,1: single, multi-bit fill ECC
// - Bits 2..6 data, tags, TLBs; rest zero
// - Mask bit blocks writing control one
// - Log fields and valid even when disabled
// - Second error while valid sets overflow
// - Enabled flag records local enable state
// - Misc valid flag always reads zero
// - Extended code and error code fields
// - Low eight syndrome bits on ECC
// - Correctable and uncorrectable ECC flags
// - Scrub flag and scrub error settings
// - Line fill error field settings
// - Tag and TLB error field settings
// - Context corrupt when state may break
// - Address meaningful only with address valid
// - Address window depends on error source
// - Overwrite priority; uncorrected never overwritten
`timescale 1ns/1ps
module dcmcb_bank
	import dcmcb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic globalDcacheEnable,
	input wire logic errValid,
	input wire dcmcb_src_t errSource,
	input wire logic errMultiBit,
	input wire logic errAddrKnown,
	input wire logic [7:0] errSyndrome,
	input wire logic [15:0] errCode,
	input wire logic [DCMCB_ADDR_W-1:0] errAddr,
	input wire logic msrRdEn,
	input wire logic msrWrEn,
	input wire logic [31:0] msrAddr,
	input wire logic [63:0] msrWrData,
	output logic [63:0] msrRdData,
	output logic msrAck,
	output logic msrMiss,
	output logic msrGpFault,
	output logic mcException
);

	// ****************************************
	// Register state
	// ****************************************
	logic [DCMCB_CTL_W-1:0] enable_r;
	logic [63:0] mask_r;
	logic [63:0] status_r;
	logic [DCMCB_ADDR_W-1:0] addrLog_r;
	logic [63:0] rdData_r;
	logic ack_r;
	logic miss_r;
	logic gpFault_r;
	logic exception_r;

	// ****************************************
	// Error classification
	// ****************************************
	logic [63:0] fieldWord;
	logic [2:0] enableIdx;
	logic [5:0] addrHi;
	logic [5:0] addrLo;
	logic [DCMCB_ADDR_W-1:0] addrWindowed;

	dcmcb_classify u_classify (
		.errSource(errSource),
		.errMultiBit(errMultiBit),
		.errAddrKnown(errAddrKnown),
		.errSyndrome(errSyndrome),
		.errCode(errCode),
		.fieldWord(fieldWord),
		.enableIdx(enableIdx),
		.addrHi(addrHi),
		.addrLo(addrLo)
	);

	dcmcb_addr_window u_addr_window (
		.addrIn(errAddr),
		.bitHi(addrHi),
		.bitLo(addrLo),
		.addrOut(addrWindowed)
	);

	// ****************************************
	// Access decode
	// ****************************************
	logic selEnable, selStatus, selAddr, selMask, selAny;
	logic wrEnable, wrStatus, wrAddr, wrMask;
	logic statusClear, statusBadWrite;

	assign selEnable = (msrAddr == DCMCB_ADDR_REPORT_ENABLE);
	assign selStatus = (msrAddr == DCMCB_ADDR_STATUS_LOG);
	assign selAddr = (msrAddr == DCMCB_ADDR_ADDRESS_LOG);
	assign selMask = (msrAddr == DCMCB_ADDR_WRITE_MASK);
	assign selAny = selEnable || selStatus || selAddr || selMask;
	assign wrEnable = msrWrEn && selEnable;
	assign wrStatus = msrWrEn && selStatus;
	assign wrAddr = msrWrEn && selAddr;
	assign wrMask = msrWrEn && selMask;
	// Only an all-zero write clears the log; anything else is refused
	assign statusClear = wrStatus && (msrWrData == 64'h0);
	assign statusBadWrite = wrStatus && (msrWrData != 64'h0);

	// ****************************************
	// Logging decision
	// ****************************************
	logic errAccept;
	logic localEnable;
	logic oldValid, oldUc, oldEn;
	logic replaceLog;

	assign errAccept = errValid && globalDcacheEnable;
	assign localEnable = enable_r[enableIdx];
	assign oldValid = status_r[DCMCB_ST_VALID];
	assign oldUc = status_r[DCMCB_ST_UC];
	assign oldEn = status_r[DCMCB_ST_EN];
	// An uncorrected entry is never displaced; otherwise uncorrected beats
	// corrected and enabled beats disabled
	assign replaceLog = !oldValid || (!oldUc &&
		(fieldWord[DCMCB_ST_UC] || (localEnable && !oldEn)));

	// ****************************************
	// Control and mask registers
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_r <= DCMCB_CTL_RESET;
		end else if (wrEnable) begin
			// Masked bits are forced to zero; upper bits are not stored
			enable_r <= msrWrData[DCMCB_CTL_W-1:0] &
				~mask_r[DCMCB_CTL_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_r <= DCMCB_MASK_RESET;
		end else if (wrMask) begin
			mask_r <= msrWrData;
		end
	end

	// ****************************************
	// Status log
	// ****************************************
	// A detected error wins over a software clear in the same cycle, so
	// no event is lost; software then sees the fresh entry, or the kept one with overflow set.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_r <= DCMCB_STATUS_RESET;
		end else if (errAccept) begin
			if (replaceLog) begin
				status_r <= fieldWord;
				status_r[DCMCB_ST_VALID] <= 1'b1;
				status_r[DCMCB_ST_OVER] <= oldValid;
				status_r[DCMCB_ST_EN] <= localEnable;
				status_r[DCMCB_ST_MISC_INFO_VALID_FLAG] <= 1'b0;
			end else begin
				status_r[DCMCB_ST_OVER] <= 1'b1;
			end
		end else if (statusClear) begin
			status_r <= DCMCB_STATUS_RESET;
		end
	end

	// ****************************************
	// Address log
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addrLog_r <= DCMCB_ADDRLOG_RESET;
		end else if (errAccept && replaceLog) begin
			addrLog_r <= addrWindowed;
		end else if (wrAddr) begin
			addrLog_r <= msrWrData[DCMCB_ADDR_W-1:0];
		end
	end

	// ****************************************
	// Exception signalling
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			exception_r <= 1'b0;
		end else begin
			exception_r <= errAccept && localEnable;
		end
	end

	// ****************************************
	// Register read port
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_r <= 64'h0;
		end else if (msrRdEn) begin
			rdData_r <= 64'h0;
			if (selEnable) begin
				rdData_r[DCMCB_CTL_W-1:0] <= enable_r;
			end
			if (selStatus) begin
				rdData_r <= status_r;
			end
			if (selAddr) begin
				rdData_r[DCMCB_ADDR_W-1:0] <= addrLog_r;
			end
			if (selMask) begin
				rdData_r <= mask_r;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
			miss_r <= 1'b0;
			gpFault_r <= 1'b0;
		end else begin
			ack_r <= (msrRdEn || msrWrEn) && selAny;
			miss_r <= (msrRdEn || msrWrEn) && !selAny;
			gpFault_r <= statusBadWrite;
		end
	end

	assign msrRdData = rdData_r;
	assign msrAck = ack_r;
	assign msrMiss = miss_r;
	assign msrGpFault = gpFault_r;
	assign mcException = exception_r;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence seqErrTaken;
		errValid && globalDcacheEnable;
	endsequence

	sequence seqErrOnEmpty;
		seqErrTaken ##0 !status_r[DCMCB_ST_VALID];
	endsequence

	a_exc_both_enables: assert property (
		mcException |-> $past(errValid && globalDcacheEnable &&
		enable_r[enableIdx]))
		else $error("exception without both enables");

	a_disabled_logged_quiet: assert property (
		(seqErrOnEmpty ##0 !enable_r[enableIdx]) |=>
		(status_r[DCMCB_ST_VALID] && !mcException))
		else $error("locally disabled error misreported");

	a_global_off_silent: assert property (
		(errValid && !globalDcacheEnable && !wrStatus) |=>
		($stable(status_r) && !mcException))
		else $error("error taken while global enable clear");

	a_mask_blocks_set: assert property (
		wrEnable |=> ((enable_r & $past(mask_r[DCMCB_CTL_W-1:0])) == 7'h00))
		else $error("masked control bit was set");

	a_log_sets_valid: assert property (
		seqErrTaken |=> status_r[DCMCB_ST_VALID])
		else $error("valid flag not set after error");

	a_second_overflows: assert property (
		(seqErrTaken ##0 status_r[DCMCB_ST_VALID]) |=>
		status_r[DCMCB_ST_OVER])
		else $error("overflow flag missing on second error");

	a_enable_recorded: assert property (
		(seqErrOnEmpty) |=>
		(status_r[DCMCB_ST_EN] == $past(enable_r[enableIdx])))
		else $error("enabled flag does not match control");

	a_misc_always_zero: assert property (
		!status_r[DCMCB_ST_MISC_INFO_VALID_FLAG] && !status_r[56] && !status_r[55])
		else $error("misc valid or reserved status bit set");

	a_uc_not_overwritten: assert property (
		(status_r[DCMCB_ST_VALID] && status_r[DCMCB_ST_UC] && !wrStatus)
		|=> $stable(status_r[DCMCB_ST_UC:0]))
		else $error("uncorrected entry overwritten");

	a_zero_clears_only: assert property (
		(statusBadWrite && !errAccept) |=>
		($stable(status_r) && msrGpFault))
		else $error("nonzero status write not refused");

	a_ctl_reserved_zero: assert property (
		(msrRdEn && selEnable) |=> (msrRdData[63:DCMCB_CTL_W] == 57'h0))
		else $error("reserved control bits read nonzero");

endmodule

// ==== common/dcmcb_pkg.sv ====
// Package of constants and types for the data cache machine check bank
package dcmcb_pkg;

	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [31:0] DCMCB_ADDR_REPORT_ENABLE = 32'h0000_0400;
	localparam logic [31:0] DCMCB_ADDR_STATUS_LOG = 32'h0000_0401;
	localparam logic [31:0] DCMCB_ADDR_ADDRESS_LOG = 32'h0000_0402;
	localparam logic [31:0] DCMCB_ADDR_WRITE_MASK = 32'hC001_0044;

	// ****************************************
	// Control register layout
	// ****************************************
	localparam int DCMCB_CTL_W = 7;
	localparam logic [2:0] DCMCB_EN_SINGLE_FILL = 3'h0;
	localparam logic [2:0] DCMCB_EN_MULTI_FILL = 3'h1;
	localparam logic [2:0] DCMCB_EN_DATA_ECC = 3'h2;
	localparam logic [2:0] DCMCB_EN_MAIN_TAG = 3'h3;
	localparam logic [2:0] DCMCB_EN_SNOOP_TAG = 3'h4;
	localparam logic [2:0] DCMCB_EN_L1_TLB = 3'h5;
	localparam logic [2:0] DCMCB_EN_L2_TLB = 3'h6;
	localparam logic [DCMCB_CTL_W-1:0] DCMCB_CTL_RESET = 7'h00;
	localparam logic [63:0] DCMCB_MASK_RESET = 64'h0;

	// ****************************************
	// Status register layout
	// ****************************************
	localparam int DCMCB_ST_VALID = 63;
	localparam int DCMCB_ST_OVER = 62;
	localparam int DCMCB_ST_UC = 61;
	localparam int DCMCB_ST_EN = 60;
	localparam int DCMCB_ST_MISC_INFO_VALID_FLAG = 59;
	localparam int DCMCB_ST_ADDRESS_VALID_FLAG = 58;
	localparam int DCMCB_ST_PCC = 57;
	localparam int DCMCB_ST_SYND_HI = 54;
	localparam int DCMCB_ST_SYND_LO = 47;
	localparam int DCMCB_ST_CORRECTABLE_ECC_FLAG = 46;
	localparam int DCMCB_ST_UNCORRECTABLE_ECC_FLAG = 45;
	localparam int DCMCB_ST_SCRUB = 40;
	localparam int DCMCB_ST_EXT_HI = 19;
	localparam int DCMCB_ST_EXT_LO = 16;
	localparam int DCMCB_ST_CODE_HI = 15;
	localparam logic [63:0] DCMCB_STATUS_RESET = 64'h0;
	localparam logic [3:0] DCMCB_EXT_PHYS_PARITY = 4'h0;
	localparam logic [3:0] DCMCB_EXT_MULTI_MATCH = 4'h1;

	// ****************************************
	// Address register
	// ****************************************
	localparam int DCMCB_ADDR_W = 48;
	localparam logic [47:0] DCMCB_ADDRLOG_RESET = 48'h0;

	// Error source reported by the detectors
	typedef enum logic [3:0] {
		DCMCB_SRC_SYS_FILL = 4'h0,
		DCMCB_SRC_L2_FILL = 4'h1,
		DCMCB_SRC_DATA_LDST = 4'h2,
		DCMCB_SRC_DATA_VICSNP = 4'h3,
		DCMCB_SRC_DATA_SCRUB = 4'h4,
		DCMCB_SRC_TAG_SNPVIC = 4'h5,
		DCMCB_SRC_TAG_LDST = 4'h6,
		DCMCB_SRC_L1_TLB = 4'h7,
		DCMCB_SRC_L1_TLB_MM = 4'h8,
		DCMCB_SRC_L2_TLB = 4'h9,
		DCMCB_SRC_L2_TLB_MM = 4'hA
	} dcmcb_src_t;

endpackage

// ==== verilog/dcmcb_addr_window.sv ====
// Keeps only the valid window of a captured error address
`timescale 1ns/1ps
module dcmcb_addr_window
	import dcmcb_pkg::*;
(
	input wire logic [DCMCB_ADDR_W-1:0] addrIn,
	input wire logic [5:0] bitHi,
	input wire logic [5:0] bitLo,
	output logic [DCMCB_ADDR_W-1:0] addrOut
);

	always_comb begin
		for (int i = 0; i < DCMCB_ADDR_W; i++) begin
			addrOut[i] = addrIn[i] && (i <= int'(bitHi)) &&
				(i >= int'(bitLo));
		end
	end

	a_addr_window_only: assert property (@(addrOut)
		((addrOut >> bitLo) << bitLo) == addrOut)
		else $error("address bit kept below the valid window");

endmodule

// ==== verilog/dcmcb_classify.sv ====
// Turns an error source into status fields, enable index and address window
`timescale 1ns/1ps
module dcmcb_classify
	import dcmcb_pkg::*;
(
	input wire dcmcb_src_t errSource,
	input wire logic errMultiBit,
	input wire logic errAddrKnown,
	input wire logic [7:0] errSyndrome,
	input wire logic [15:0] errCode,
	output logic [63:0] fieldWord,
	output logic [2:0] enableIdx,
	output logic [5:0] addrHi,
	output logic [5:0] addrLo
);

	logic uc, context_corrupt_flag, address_valid_flag, syndValid, eccFlags, scrub;
	logic [3:0] ext;

	always_comb begin
		uc = 1'b1;
		context_corrupt_flag = 1'b1;
		address_valid_flag = 1'b1;
		syndValid = 1'b0;
		eccFlags = 1'b0;
		scrub = 1'b0;
		ext = DCMCB_EXT_PHYS_PARITY;
		enableIdx = DCMCB_EN_DATA_ECC;
		addrHi = 6'd39;
		addrLo = 6'd3;
		case (errSource)
			DCMCB_SRC_SYS_FILL, DCMCB_SRC_L2_FILL: begin
				uc = errMultiBit;
				context_corrupt_flag = errMultiBit;
				syndValid = 1'b1;
				eccFlags = 1'b1;
				enableIdx = errMultiBit ? DCMCB_EN_MULTI_FILL :
					DCMCB_EN_SINGLE_FILL;
				addrLo = 6'd6;
			end
			DCMCB_SRC_DATA_LDST: begin
				syndValid = 1'b1;
				eccFlags = 1'b1;
			end
			DCMCB_SRC_DATA_VICSNP: begin
				syndValid = 1'b1;
				eccFlags = 1'b1;
				address_valid_flag = errAddrKnown;
				addrHi = 6'd11;
				addrLo = 6'd6;
			end
			DCMCB_SRC_DATA_SCRUB: begin
				uc = errMultiBit;
				context_corrupt_flag = 1'b0;
				syndValid = 1'b1;
				eccFlags = 1'b1;
				scrub = 1'b1;
				addrHi = 6'd11;
			end
			DCMCB_SRC_TAG_SNPVIC: begin
				address_valid_flag = errAddrKnown;
				enableIdx = DCMCB_EN_SNOOP_TAG;
				addrHi = 6'd11;
				addrLo = 6'd6;
			end
			DCMCB_SRC_TAG_LDST: begin
				enableIdx = DCMCB_EN_MAIN_TAG;
			end
			DCMCB_SRC_L1_TLB, DCMCB_SRC_L1_TLB_MM: begin
				enableIdx = DCMCB_EN_L1_TLB;
				addrHi = 6'd47;
				addrLo = 6'd12;
			end
			DCMCB_SRC_L2_TLB, DCMCB_SRC_L2_TLB_MM: begin
				enableIdx = DCMCB_EN_L2_TLB;
				addrHi = 6'd47;
				addrLo = 6'd12;
			end
			default: begin
				address_valid_flag = 1'b0;
			end
		endcase
		if (errSource == DCMCB_SRC_L1_TLB_MM ||
			errSource == DCMCB_SRC_L2_TLB_MM) begin
			ext = DCMCB_EXT_MULTI_MATCH;
		end
		fieldWord = DCMCB_STATUS_RESET;
		fieldWord[DCMCB_ST_UC] = uc;
		fieldWord[DCMCB_ST_ADDRESS_VALID_FLAG] = address_valid_flag;
		fieldWord[DCMCB_ST_PCC] = context_corrupt_flag;
		if (syndValid) begin
			fieldWord[DCMCB_ST_SYND_HI:DCMCB_ST_SYND_LO] = errSyndrome;
		end
		fieldWord[DCMCB_ST_CORRECTABLE_ECC_FLAG] = eccFlags && !errMultiBit;
		fieldWord[DCMCB_ST_UNCORRECTABLE_ECC_FLAG] = eccFlags && errMultiBit;
		fieldWord[DCMCB_ST_SCRUB] = scrub;
		fieldWord[DCMCB_ST_EXT_HI:DCMCB_ST_EXT_LO] = ext;
		fieldWord[DCMCB_ST_CODE_HI:0] = errCode;
	end

	a_tag_tlb_fields: assert property (@(fieldWord)
		(errSource >= DCMCB_SRC_TAG_SNPVIC && errSource <= DCMCB_SRC_L2_TLB_MM)
		|-> (fieldWord[DCMCB_ST_UC] && fieldWord[DCMCB_ST_PCC] &&
		!fieldWord[DCMCB_ST_CORRECTABLE_ECC_FLAG] && !fieldWord[DCMCB_ST_UNCORRECTABLE_ECC_FLAG]))
		else $error("tag or TLB error classified wrongly");

endmodule

// ==== dv/dcmcb_err_model.sv ====
// Behavioural model of the data cache error detectors and exception sink
`timescale 1ns/1ps
module dcmcb_err_model
	import dcmcb_pkg::*;
(
	input wire logic clk,
	input wire logic mcException,
	output logic errValid,
	output dcmcb_src_t errSource,
	output logic errMultiBit,
	output logic errAddrKnown,
	output logic [7:0] errSyndrome,
	output logic [15:0] errCode,
	output logic [47:0] errAddr,
	output int excCount
);
	// One process owns the exception counter so the port has a single driver
	int excCnt = 0;

	assign excCount = excCnt;

	initial begin
		errValid = 1'h0;
		errSource = DCMCB_SRC_SYS_FILL;
		errMultiBit = 1'h0;
		errAddrKnown = 1'h0;
		errSyndrome = 8'h00;
		errCode = 16'h0000;
		errAddr = 48'h0;
	end

	// ****************************************
	// Error injection, one pulse per error
	// ****************************************
	task automatic inject(input dcmcb_src_t s, input logic m, input logic k,
		input logic [7:0] sy, input logic [15:0] c, input logic [47:0] a);
		@(posedge clk);
		errValid <= 1'h1;
		errSource <= s;
		errMultiBit <= m;
		errAddrKnown <= k;
		errSyndrome <= sy;
		errCode <= c;
		errAddr <= a;
		@(posedge clk);
		errValid <= 1'h0;
		// Stale qualifiers are inverted so a late sample cannot pass
		errMultiBit <= ~m;
		errAddrKnown <= ~k;
		errSyndrome <= ~sy;
		errCode <= ~c;
		errAddr <= ~a;
	endtask

	always @(posedge clk) begin
		if (mcException === 1'b1) begin
			excCnt <= excCnt + 1;
		end
	end
endmodule

// ==== dv/dcmcb_bank_tb_top.sv ====
// Self-checking bench for the data cache machine check bank
`timescale 1ns/1ps
module dcmcb_bank_tb_top
	import dcmcb_pkg::*;
();
	localparam logic [31:0] A_CTL = DCMCB_ADDR_REPORT_ENABLE;
	localparam logic [31:0] A_ST = DCMCB_ADDR_STATUS_LOG;
	localparam logic [31:0] A_AD = DCMCB_ADDR_ADDRESS_LOG;
	localparam logic [31:0] A_MK = DCMCB_ADDR_WRITE_MASK;
	localparam logic [6:0] CTL_PAT = 7'h55;
	logic clk, rst_n, globalDcacheEnable, msrRdEn, msrWrEn;
	logic [31:0] msrAddr;
	logic [63:0] msrWrData, msrRdData, rdv, lastS;
	logic msrAck, msrMiss, msrGpFault, mcException, gotMiss, gotGp;
	logic errValid, errMultiBit, errAddrKnown, m, en;
	dcmcb_src_t errSource, s;
	logic [7:0] errSyndrome;
	logic [15:0] errCode;
	logic [47:0] errAddr, a;
	int excCount, n_mismatch, num_checks, i, e0;

	dcmcb_bank i_dut (
		.clk(clk),
		.rst_n(rst_n),
		.globalDcacheEnable(globalDcacheEnable),
		.errValid(errValid),
		.errSource(errSource),
		.errMultiBit(errMultiBit),
		.errAddrKnown(errAddrKnown),
		.errSyndrome(errSyndrome),
		.errCode(errCode),
		.errAddr(errAddr),
		.msrRdEn(msrRdEn),
		.msrWrEn(msrWrEn),
		.msrAddr(msrAddr),
		.msrWrData(msrWrData),
		.msrRdData(msrRdData),
		.msrAck(msrAck),
		.msrMiss(msrMiss),
		.msrGpFault(msrGpFault),
		.mcException(mcException)
	);

	dcmcb_err_model i_src (
		.clk(clk),
		.mcException(mcException),
		.errValid(errValid),
		.errSource(errSource),
		.errMultiBit(errMultiBit),
		.errAddrKnown(errAddrKnown),
		.errSyndrome(errSyndrome),
		.errCode(errCode),
		.errAddr(errAddr),
		.excCount(excCount)
	);

	always #2.5 clk = ~clk;

	// ****************************************
	// Access, compare and expectation helpers
	// ****************************************
	task automatic complete_run();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic access(input logic wr, input logic [31:0] ad,
		input logic [63:0] d);
		int k;
		@(posedge clk);
		msrRdEn <= ~wr;
		msrWrEn <= wr;
		msrAddr <= ad;
		msrWrData <= d;
		@(posedge clk);
		msrRdEn <= 1'h0;
		msrWrEn <= 1'h0;
		#1;
		for (k = 0; k < 8 && msrAck !== 1'b1 && msrMiss !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		if (k == 8) begin
			n_mismatch++;
			$display("FAIL %0t register port gave no answer", $time);
			complete_run();
		end
		rdv = msrRdData;
		gotMiss = msrMiss;
		gotGp = msrGpFault;
	endtask

	task automatic rd(input logic [31:0] ad, input logic [63:0] exp);
		access(1'b0, ad, 64'h0);
		chk64(rdv, exp);
	endtask

	function automatic int enIdx(input dcmcb_src_t t, input logic mb);
		case (t)
			DCMCB_SRC_SYS_FILL, DCMCB_SRC_L2_FILL: return mb ? 1 : 0;
			DCMCB_SRC_TAG_LDST: return 3;
			DCMCB_SRC_TAG_SNPVIC: return 4;
			DCMCB_SRC_L1_TLB, DCMCB_SRC_L1_TLB_MM: return 5;
			DCMCB_SRC_L2_TLB, DCMCB_SRC_L2_TLB_MM: return 6;
			default: return 2;
		endcase
	endfunction

	function automatic logic [63:0] expSt(input dcmcb_src_t t,
		input logic mb, input logic [7:0] sy, input logic [15:0] c,
		input logic e, input logic ov);
		logic [63:0] v;
		v = 64'h0;
		v[63] = 1'b1;
		v[62] = ov;
		v[60] = e;
		v[15:0] = c;
		v[19:16] = (t == DCMCB_SRC_L1_TLB_MM || t == DCMCB_SRC_L2_TLB_MM);
		v[40] = (t == DCMCB_SRC_DATA_SCRUB);
		v[61] = 1'b1;
		v[58] = 1'b1;
		v[57] = 1'b1;
		if (t <= DCMCB_SRC_DATA_SCRUB) begin
			v[54:47] = sy;
			v[46] = ~mb;
			v[45] = mb;
		end
		if (t <= DCMCB_SRC_L2_FILL || t == DCMCB_SRC_DATA_SCRUB) begin
			v[61] = mb;
			v[57] = mb && t != DCMCB_SRC_DATA_SCRUB;
		end
		if (t == DCMCB_SRC_DATA_VICSNP || t == DCMCB_SRC_TAG_SNPVIC) begin
			v[58] = mb;
		end
		return v;
	endfunction

	function automatic logic [47:0] expAd(input dcmcb_src_t t,
		input logic [47:0] ad);
		int hi, lo;
		case (t)
			DCMCB_SRC_SYS_FILL, DCMCB_SRC_L2_FILL: begin
				hi = 39;
				lo = 6;
			end
			DCMCB_SRC_DATA_LDST, DCMCB_SRC_TAG_LDST: begin
				hi = 39;
				lo = 3;
			end
			DCMCB_SRC_DATA_SCRUB: begin
				hi = 11;
				lo = 3;
			end
			DCMCB_SRC_DATA_VICSNP, DCMCB_SRC_TAG_SNPVIC: begin
				hi = 11;
				lo = 6;
			end
			default: begin
				hi = 47;
				lo = 12;
			end
		endcase
		for (int b = 0; b < 48; b++) begin
			if (b > hi || b < lo) begin
				ad[b] = 1'b0;
			end
		end
		return ad;
	endfunction

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		globalDcacheEnable = 1'b0;
		msrRdEn = 1'b0;
		msrWrEn = 1'b0;
		msrAddr = 32'h0;
		msrWrData = 64'h0;
		n_mismatch = 0;
		num_checks = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd(A_CTL, 64'h0);
		rd(A_ST, 64'h0);
		rd(A_AD, 64'h0);
		rd(A_MK, 64'h0);
		rd(32'h0000_0403, 64'h0);
		chk1(gotMiss, 1'b1);
		access(1'b1, A_CTL, 64'hFFFF_FFFF_FFFF_FFFF);
		rd(A_CTL, 64'h7F);
		access(1'b1, A_MK, 64'hA5A5_0000_0000_0005);
		rd(A_MK, 64'hA5A5_0000_0000_0005);
		access(1'b1, A_CTL, 64'h7F);
		rd(A_CTL, 64'h7A);
		access(1'b1, A_MK, 64'h0);
		access(1'b1, A_CTL, 64'h7F);
		access(1'b1, A_AD, 64'hFFFF_FFFF_FFFF_FFFF);
		rd(A_AD, 64'h0000_FFFF_FFFF_FFFF);
		e0 = excCount;
		i_src.inject(DCMCB_SRC_TAG_LDST, 1'b1, 1'b1, 8'h11, 16'h0F0F, 48'h1);
		rd(A_ST, 64'h0);
		rd(A_AD, 64'h0000_FFFF_FFFF_FFFF);
		chk64(64'(excCount - e0), 64'h0);
		globalDcacheEnable <= 1'b1;
		access(1'b1, A_CTL, {57'h0, CTL_PAT});
		for (i = 0; i < 22; i++) begin
			s = dcmcb_src_t'(i / 2);
			m = i[0];
			a = 48'hC3A5_F00F_9E6B ^ 48'(i);
			en = CTL_PAT[enIdx(s, m)];
			access(1'b1, A_ST, 64'h0);
			e0 = excCount;
			i_src.inject(s, m, m, 8'(i * 37), 16'(16'h1200 + i), a);
			lastS = expSt(s, m, 8'(i * 37), 16'(16'h1200 + i), en, 1'b0);
			rd(A_ST, lastS);
			rd(A_AD, {16'h0, expAd(s, a)});
			chk64(64'(excCount - e0), {63'h0, en});
		end
		access(1'b1, A_ST, 64'h1);
		chk1(gotGp, 1'b1);
		rd(A_ST, lastS);
		access(1'b1, A_ST, 64'h0);
		rd(A_ST, 64'h0);
		access(1'b1, A_CTL, 64'h1);
		a = 48'h0123_4567_89AB;
		i_src.inject(DCMCB_SRC_DATA_SCRUB, 1'b0, 1'b1, 8'h3C, 16'h0011, a);
		i_src.inject(DCMCB_SRC_SYS_FILL, 1'b0, 1'b1, 8'h3C, 16'h0022, a);
		lastS = expSt(DCMCB_SRC_SYS_FILL, 1'b0, 8'h3C, 16'h0022, 1'b1, 1'b1);
		rd(A_ST, lastS);
		rd(A_AD, {16'h0, expAd(DCMCB_SRC_SYS_FILL, a)});
		i_src.inject(DCMCB_SRC_DATA_SCRUB, 1'b0, 1'b1, 8'h3C, 16'h0033, ~a);
		rd(A_ST, lastS);
		i_src.inject(DCMCB_SRC_L1_TLB, 1'b0, 1'b1, 8'h3C, 16'h0044, a);
		lastS = expSt(DCMCB_SRC_L1_TLB, 1'b0, 8'h3C, 16'h0044, 1'b0, 1'b1);
		rd(A_ST, lastS);
		i_src.inject(DCMCB_SRC_SYS_FILL, 1'b1, 1'b1, 8'h3C, 16'h0055, ~a);
		rd(A_ST, lastS);
		rd(A_AD, {16'h0, expAd(DCMCB_SRC_L1_TLB, a)});
		complete_run();
	end
endmodule
